//--- rtl/rss_rtc_slave.sv
// Two-wire slave front end with control register 1, test-mode pre-scaler
// and power-on reset override.
// Assumes the bench resolves open-drain wires from the enables; busClock
// samples the bus far faster than the serial clock.
module rss_rtc_slave (
	input  wire logic       clock,
	input  wire logic       rst_b,
	input  wire logic       busClock,
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOe_b,
	input  wire logic       sqwIn,
	output logic            sqwOut,
	output logic            sqwOe_b,
	input  wire logic       squareWaveSource,
	input  wire logic       tick64In,
	input  wire logic       oscStable,
	output logic [7:0]      regRdAddr,
	input  wire logic [7:0] regRdData,
	output logic [7:0]      regWrAddr,
	output logic [7:0]      regWrData,
	output logic            regWrStrobe,
	output logic            secondTick,
	output logic            internalRst_b
);

	// Bus domain
	logic                    sclLvl;
	logic                    sclRise;
	logic                    sclFall;
	logic                    sdaLvl;
	logic                    sdaRise;
	logic                    sdaFall;
	rss_pkg::rss_bus_state_e busState;
	logic [3:0]              bitCnt;
	logic [7:0]              shiftReg;
	logic                    rwReg;
	logic                    addrPhase;
	logic                    masterAck;
	logic [7:0]              ctrl1Reg;
	logic [7:0]              txByte;
	logic                    startSeen;
	logic                    stopSeen;
	logic                    byteDone;
	logic                    sampleBit;
	logic                    addrMatch;
	logic                    addrDone;
	logic                    rxDone;
	logic                    txNext;
	logic                    txDone;

	// System domain
	logic                    testModeSync;
	logic                    haltSync;
	logic                    permitSync;
	logic                    sqwRise;
	logic                    tickRise;
	logic                    oscSync;
	logic                    sclSys;
	logic                    sdaSys;
	logic                    countEdge;
	logic [5:0]              prescaleReg;
	rss_pkg::rss_ovr_state_e ovState;
	logic [7:0]              ovHoldReg;
	logic                    ovHoldDone;
	logic [1:0]              ovPins;
	logic                    overrideActive;

	function automatic logic [1:0] ovPattern(input rss_pkg::rss_ovr_state_e s);
		unique case (s)
			rss_pkg::OV_IDLE:     ovPattern = rss_pkg::PINS_IDLE;
			rss_pkg::OV_SDA_LOW:  ovPattern = rss_pkg::PINS_SDA_LOW;
			rss_pkg::OV_SCL_LOW:  ovPattern = rss_pkg::PINS_SCL_LOW;
			rss_pkg::OV_SDA_HIGH: ovPattern = rss_pkg::PINS_SDA_HIGH;
			rss_pkg::OV_DONE:     ovPattern = rss_pkg::PINS_IDLE;
			default:              ovPattern = rss_pkg::PINS_IDLE;
		endcase
	endfunction

	function automatic rss_pkg::rss_ovr_state_e ovNext(input rss_pkg::rss_ovr_state_e s);
		unique case (s)
			rss_pkg::OV_IDLE:     ovNext = rss_pkg::OV_SDA_LOW;
			rss_pkg::OV_SDA_LOW:  ovNext = rss_pkg::OV_SCL_LOW;
			rss_pkg::OV_SCL_LOW:  ovNext = rss_pkg::OV_SDA_HIGH;
			rss_pkg::OV_SDA_HIGH: ovNext = rss_pkg::OV_DONE;
			rss_pkg::OV_DONE:     ovNext = rss_pkg::OV_DONE;
			default:              ovNext = rss_pkg::OV_IDLE;
		endcase
	endfunction

	rss_pin_sync uSclBus (.clock(busClock), .rst_b(rst_b), .pinIn(sclIn),
		.level(sclLvl), .rise(sclRise), .fall(sclFall));
	rss_pin_sync uSdaBus (.clock(busClock), .rst_b(rst_b), .pinIn(sdaIn),
		.level(sdaLvl), .rise(sdaRise), .fall(sdaFall));

	// SDA edges with SCL high are conditions only, never data
	assign startSeen = sclLvl & sdaFall;
	assign stopSeen  = sclLvl & sdaRise;
	assign byteDone  = sclFall & (bitCnt == rss_pkg::BYTE_BITS);
	assign sampleBit = sclRise & ((busState == rss_pkg::BUS_ADDR) |
		(busState == rss_pkg::BUS_RX));
	assign addrMatch = (shiftReg[7:1] == rss_pkg::SLAVE_ADDR);
	assign addrDone  = (busState == rss_pkg::BUS_ADDR) & byteDone;
	assign rxDone    = (busState == rss_pkg::BUS_RX) & byteDone;
	assign txNext    = (busState == rss_pkg::BUS_TX) & sclFall &
		(bitCnt != rss_pkg::BYTE_BITS);
	assign txDone    = (busState == rss_pkg::BUS_TX) & byteDone;
	assign txByte    = (regRdAddr == rss_pkg::CTRL1_ADDR) ? ctrl1Reg : regRdData;

	always_ff @(posedge busClock or negedge rst_b) begin
		if (!rst_b) begin
			busState <= rss_pkg::BUS_IDLE;
			bitCnt   <= 4'h0;
		end else if (stopSeen) begin
			busState <= rss_pkg::BUS_IDLE;
			bitCnt   <= 4'h0;
		end else if (startSeen) begin
			busState <= rss_pkg::BUS_ADDR;
			bitCnt   <= 4'h0;
		end else begin
			unique case (busState)
				rss_pkg::BUS_IDLE, rss_pkg::BUS_WAIT_STOP: begin
					bitCnt <= 4'h0;
				end
				rss_pkg::BUS_ADDR: begin
					if (addrDone) begin
						busState <= addrMatch ? rss_pkg::BUS_ADDR_ACK : rss_pkg::BUS_IDLE;
						bitCnt   <= 4'h0;
					end else if (sampleBit) begin
						bitCnt <= bitCnt + 4'h1;
					end
				end
				rss_pkg::BUS_ADDR_ACK: begin
					if (sclFall) begin
						busState <= rwReg ? rss_pkg::BUS_TX : rss_pkg::BUS_RX;
						bitCnt   <= rwReg ? rss_pkg::FIRST_TX : 4'h0;
					end
				end
				rss_pkg::BUS_RX: begin
					if (rxDone) begin
						busState <= rss_pkg::BUS_RX_ACK;
						bitCnt   <= 4'h0;
					end else if (sampleBit) begin
						bitCnt <= bitCnt + 4'h1;
					end
				end
				rss_pkg::BUS_RX_ACK: begin
					if (sclFall) begin
						busState <= rss_pkg::BUS_RX;
					end
				end
				rss_pkg::BUS_TX: begin
					if (txDone) begin
						busState <= rss_pkg::BUS_TX_ACK;
						bitCnt   <= 4'h0;
					end else if (txNext) begin
						bitCnt <= bitCnt + 4'h1;
					end
				end
				rss_pkg::BUS_TX_ACK: begin
					if (sclFall) begin
						busState <= masterAck ? rss_pkg::BUS_TX : rss_pkg::BUS_WAIT_STOP;
						bitCnt   <= rss_pkg::FIRST_TX;
					end
				end
			endcase
		end
	end

	// Shift path, direction and acknowledge capture
	always_ff @(posedge busClock or negedge rst_b) begin
		if (!rst_b) begin
			shiftReg  <= 8'h00;
			rwReg     <= 1'h0;
			addrPhase <= 1'h0;
			masterAck <= 1'h0;
		end else begin
			if (sampleBit) begin
				shiftReg <= {shiftReg[6:0], sdaLvl};
			end else if (sclFall && ((busState == rss_pkg::BUS_ADDR_ACK && rwReg) ||
				(busState == rss_pkg::BUS_TX_ACK && masterAck))) begin
				shiftReg <= txByte;
			end else if (txNext) begin
				shiftReg <= {shiftReg[6:0], 1'h0};
			end
			if (addrDone) begin
				rwReg     <= shiftReg[0];
				addrPhase <= ~shiftReg[0];
			end else if (rxDone) begin
				addrPhase <= 1'h0;
			end
			if (busState == rss_pkg::BUS_TX_ACK && sclRise) begin
				masterAck <= ~sdaLvl;
			end
		end
	end

	// Pointer, control register 1 and outside write port
	always_ff @(posedge busClock or negedge rst_b) begin
		if (!rst_b) begin
			regRdAddr   <= 8'h00;
			regWrAddr   <= 8'h00;
			regWrData   <= 8'h00;
			regWrStrobe <= 1'h0;
			ctrl1Reg    <= rss_pkg::CTRL1_RESET;
		end else begin
			regWrStrobe <= 1'h0;
			if (rxDone && addrPhase) begin
				regRdAddr <= shiftReg;
			end else if (rxDone) begin
				if (regRdAddr == rss_pkg::CTRL1_ADDR) begin
					ctrl1Reg <= shiftReg;
				end else begin
					regWrStrobe <= 1'h1;
					regWrAddr   <= regRdAddr;
					regWrData   <= shiftReg;
				end
				regRdAddr <= regRdAddr + 8'h01;
			end else if (txDone) begin
				regRdAddr <= regRdAddr + 8'h01;
			end
		end
	end

	// Open drain: only ever pull low or release
	always_ff @(posedge busClock or negedge rst_b) begin
		if (!rst_b) begin
			sdaOut  <= 1'h0;
			sdaOe_b <= 1'h1;
		end else begin
			sdaOut <= 1'h0;
			if (startSeen || stopSeen) begin
				sdaOe_b <= 1'h1;
			end else if ((addrDone && addrMatch) || rxDone) begin
				sdaOe_b <= 1'h0;
			end else if (busState == rss_pkg::BUS_ADDR_ACK && sclFall) begin
				sdaOe_b <= rwReg ? txByte[7] : 1'h1;
			end else if (busState == rss_pkg::BUS_RX_ACK && sclFall) begin
				sdaOe_b <= 1'h1;
			end else if (txNext) begin
				sdaOe_b <= shiftReg[6];
			end else if (txDone) begin
				sdaOe_b <= 1'h1;
			end else if (busState == rss_pkg::BUS_TX_ACK && sclFall) begin
				sdaOe_b <= masterAck ? txByte[7] : 1'h1;
			end
		end
	end

	// Control bits cross as levels
	// Idle-low inputs reset low: no false test mode or reset release after reset
	rss_pin_sync #(.RESET_VAL(1'h0)) uTestCross (.clock(clock), .rst_b(rst_b),
		.pinIn(ctrl1Reg[rss_pkg::EXT_CLOCK_TEST_SELECT_BIT]), .level(testModeSync), .rise(), .fall());
	rss_pin_sync #(.RESET_VAL(1'h0)) uHaltCross (.clock(clock), .rst_b(rst_b),
		.pinIn(ctrl1Reg[rss_pkg::HALT_BIT]), .level(haltSync), .rise(), .fall());
	rss_pin_sync uPermitCross (.clock(clock), .rst_b(rst_b),
		.pinIn(ctrl1Reg[rss_pkg::PERMIT_BIT]), .level(permitSync), .rise(), .fall());
	rss_pin_sync #(.RESET_VAL(1'h0)) uSqwSys (.clock(clock), .rst_b(rst_b), .pinIn(sqwIn),
		.level(), .rise(sqwRise), .fall());
	rss_pin_sync #(.RESET_VAL(1'h0)) uTickSys (.clock(clock), .rst_b(rst_b), .pinIn(tick64In),
		.level(), .rise(tickRise), .fall());
	rss_pin_sync #(.RESET_VAL(1'h0)) uOscSys (.clock(clock), .rst_b(rst_b), .pinIn(oscStable),
		.level(oscSync), .rise(), .fall());
	rss_pin_sync uSclSys (.clock(clock), .rst_b(rst_b), .pinIn(sclIn),
		.level(sclSys), .rise(), .fall());
	rss_pin_sync uSdaSys (.clock(clock), .rst_b(rst_b), .pinIn(sdaIn),
		.level(sdaSys), .rise(), .fall());

	assign countEdge = testModeSync ? sqwRise : tickRise;

	// No reset on mode entry: count may start anywhere until halted
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			prescaleReg <= 6'h00;
		end else if (haltSync) begin
			prescaleReg <= 6'h00;
		end else if (countEdge) begin
			prescaleReg <= prescaleReg + 6'h01;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			secondTick <= 1'h0;
		end else begin
			secondTick <= ~haltSync & countEdge & (prescaleReg == rss_pkg::PRESCALE_FIRE);
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sqwOut  <= 1'h0;
			sqwOe_b <= 1'h0;
		end else begin
			sqwOut  <= squareWaveSource;
			sqwOe_b <= testModeSync;
		end
	end

	assign ovPins     = {sclSys, sdaSys};
	assign ovHoldDone = (ovHoldReg == rss_pkg::OVR_HOLD_CYCLES);

	// Each phase must be held its least time before the next is accepted
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ovState   <= rss_pkg::OV_IDLE;
			ovHoldReg <= 8'h00;
		end else if (!permitSync || overrideActive || ovState == rss_pkg::OV_DONE) begin
			ovState   <= rss_pkg::OV_IDLE;
			ovHoldReg <= 8'h00;
		end else if (ovHoldDone && ovPins == ovPattern(ovNext(ovState))) begin
			ovState   <= ovNext(ovState);
			ovHoldReg <= 8'h00;
		end else if (ovPins == ovPattern(ovState)) begin
			ovHoldReg <= ovHoldDone ? ovHoldReg : ovHoldReg + 8'h01;
		end else begin
			ovState   <= rss_pkg::OV_IDLE;
			ovHoldReg <= 8'h00;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			overrideActive <= 1'h0;
		end else if (!permitSync) begin
			overrideActive <= 1'h0;
		end else if (ovState == rss_pkg::OV_DONE) begin
			overrideActive <= 1'h1;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			internalRst_b <= 1'h0;
		end else begin
			internalRst_b <= oscSync | overrideActive;
		end
	end

	AST_PIN_DIRECTION: assert property (@(posedge clock) disable iff (!rst_b)
		testModeSync |=> sqwOe_b)
		else $error("square-wave pin still driven in test mode");
	AST_SOURCE_SELECT: assert property (@(posedge clock) disable iff (!rst_b)
		(testModeSync && !sqwRise && !haltSync) |=> $stable(prescaleReg))
		else $error("pre-scaler moved without a pin edge in test mode");
	AST_TICK_AT_FIRE: assert property (@(posedge clock) disable iff (!rst_b)
		secondTick |-> $past(prescaleReg) == rss_pkg::PRESCALE_FIRE && $past(countEdge))
		else $error("seconds tick outside the pre-scaler midpoint");
	AST_HALT_ZERO: assert property (@(posedge clock) disable iff (!rst_b)
		haltSync |=> (prescaleReg == 6'h00 && !secondTick))
		else $error("pre-scaler not held at zero while halted");
	AST_FIRST_TICK: assert property (@(posedge clock) disable iff (!rst_b)
		(!haltSync && countEdge && prescaleReg == rss_pkg::PRESCALE_FIRE) |=> secondTick)
		else $error("seconds tick missing on the thirty-second edge");
	AST_OVERRIDE_CLEAR: assert property (@(posedge clock) disable iff (!rst_b)
		!permitSync |=> !overrideActive)
		else $error("override held after permit cleared");
	AST_RESET_RELEASE: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(overrideActive) |-> ##1 internalRst_b)
		else $error("internal reset not released by override");
	AST_START_ADDR: assert property (@(posedge busClock) disable iff (!rst_b)
		(startSeen && !stopSeen) |=> (busState == rss_pkg::BUS_ADDR && bitCnt == 4'h0))
		else $error("start not followed by address phase");
	AST_STOP_IDLE: assert property (@(posedge busClock) disable iff (!rst_b)
		stopSeen |=> (busState == rss_pkg::BUS_IDLE && sdaOe_b))
		else $error("stop did not end the transfer");
	AST_ADDR_FILTER: assert property (@(posedge busClock) disable iff (!rst_b)
		(addrDone && !startSeen && !stopSeen) |=> (sdaOe_b == !$past(addrMatch)))
		else $error("acknowledge does not follow address match");
	AST_POINTER_STEP: assert property (@(posedge busClock) disable iff (!rst_b)
		(txDone && !startSeen && !stopSeen) |=> regRdAddr == $past(regRdAddr) + 8'h01)
		else $error("pointer not advanced after read byte");
	AST_NACK_RELEASE: assert property (@(posedge busClock) disable iff (!rst_b)
		(busState == rss_pkg::BUS_WAIT_STOP) |-> sdaOe_b)
		else $error("slave drives SDA after master refused byte");

	COV_TEST_TICK: cover property (@(posedge clock) disable iff (!rst_b)
		testModeSync && secondTick);
	COV_OVERRIDE: cover property (@(posedge clock) disable iff (!rst_b)
		$rose(overrideActive));
	COV_WRITE: cover property (@(posedge busClock) disable iff (!rst_b)
		regWrStrobe);
	COV_READ_NACK: cover property (@(posedge busClock) disable iff (!rst_b)
		busState == rss_pkg::BUS_TX_ACK ##1 busState == rss_pkg::BUS_WAIT_STOP);

endmodule

//--- rtl/rss_pkg.sv
// Shared constants and state types for the serial slave and test features.
// Assumes a 250 MHz system clock and a separate bus sampling clock.
package rss_pkg;

	// Bus identity and register map
	localparam logic [6:0] SLAVE_ADDR  = 7'h51;
	localparam logic [7:0] CTRL1_ADDR  = 8'h00;
	localparam logic [7:0] CTRL1_RESET = 8'h08;
	localparam int         EXT_CLOCK_TEST_SELECT_BIT   = 7;
	localparam int         HALT_BIT    = 5;
	localparam int         PERMIT_BIT  = 3;

	// Byte framing
	localparam logic [3:0] BYTE_BITS   = 4'h8;
	localparam logic [3:0] FIRST_TX    = 4'h1;

	// Six-stage pre-scaler; the seconds tick fires on the 31 to 32 step
	localparam int         PRESCALE_W    = 6;
	localparam logic [5:0] PRESCALE_FIRE = 6'h1f;

	// Reset override: least hold time of each pin phase
	localparam int         CLOCK_PERIOD_NS  = 4;
	localparam int         OVR_HOLD_NS      = 500;
	localparam logic [7:0] OVR_HOLD_CYCLES  =
		8'((OVR_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

	// Override pin patterns, {scl, sda}
	localparam logic [1:0] PINS_IDLE     = 2'h3;
	localparam logic [1:0] PINS_SDA_LOW  = 2'h2;
	localparam logic [1:0] PINS_SCL_LOW  = 2'h0;
	localparam logic [1:0] PINS_SDA_HIGH = 2'h1;

	typedef enum logic [2:0] {
		BUS_IDLE      = 3'h0,
		BUS_ADDR      = 3'h1,
		BUS_ADDR_ACK  = 3'h3,
		BUS_RX        = 3'h2,
		BUS_RX_ACK    = 3'h6,
		BUS_TX        = 3'h7,
		BUS_TX_ACK    = 3'h5,
		BUS_WAIT_STOP = 3'h4
	} rss_bus_state_e;

	typedef enum logic [2:0] {
		OV_IDLE     = 3'h0,
		OV_SDA_LOW  = 3'h1,
		OV_SCL_LOW  = 3'h3,
		OV_SDA_HIGH = 3'h2,
		OV_DONE     = 3'h6
	} rss_ovr_state_e;

endpackage

//--- rtl/rss_pin_sync.sv
// Two-flop synchroniser with a third stage for edge detection.
// Assumes pinIn is asynchronous to clock; level and edges are safe to use.
// Reset value must match the input's idle level, else a false edge follows reset
module rss_pin_sync #(
	parameter logic RESET_VAL = 1'h1
) (
	input  wire logic clock,
	input  wire logic rst_b,
	input  wire logic pinIn,
	output logic      level,
	output logic      rise,
	output logic      fall
);

	logic metaReg;
	logic stableReg;
	logic lastReg;

	// First stage feeds only the second
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			metaReg   <= RESET_VAL;
			stableReg <= RESET_VAL;
			lastReg   <= RESET_VAL;
		end else begin
			metaReg   <= pinIn;
			stableReg <= metaReg;
			lastReg   <= stableReg;
		end
	end

	assign level = stableReg;
	assign rise  = stableReg & ~lastReg;
	assign fall  = ~stableReg & lastReg;

endmodule

//--- tb/rss_bus_master.sv
// Two-wire bus master model; drives only open-drain enables.
// Assumes the bench resolves both wires from all enables with pull-ups.
module rss_bus_master (
	input  wire logic busClock,
	input  wire logic sda,
	output logic      sclOe_b,
	output logic      sdaOe_b
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		sclOe_b = 1'b1;
		sdaOe_b = 1'b1;
	end

	// Ten busClock periods per phase keeps above the slave's sync margin
	task automatic drive(input logic s, input logic d, input int n = 9);
		@(posedge busClock);
		sclOe_b <= s;
		sdaOe_b <= d;
		repeat (n) @(posedge busClock);
	endtask

	task automatic bitIo(input logic d, output logic q);
		drive(1'b0, sdaOe_b);
		drive(1'b0, d);
		drive(1'b1, d);
		q = sda;
	endtask

	task automatic start();
		drive(1'b0, sdaOe_b);
		drive(1'b0, 1'b1);
		drive(1'b1, 1'b1);
		drive(1'b1, 1'b0);
	endtask

	task automatic stop();
		drive(1'b0, sdaOe_b);
		drive(1'b0, 1'b0);
		drive(1'b1, 1'b0);
		drive(1'b1, 1'b1);
	endtask

	// ackLvl is what the master leaves on SDA in the ninth clock
	task automatic xfer(input logic [7:0] tx, input logic ackLvl, output logic [7:0] rx,
		output logic ack);
		for (int i = 7; i >= 0; i--) bitIo(tx[i], rx[i]);
		bitIo(ackLvl, ack);
	endtask

	// Phases of 21 busClock periods exceed the 500 ns minimum
	task automatic override();
		drive(1'b1, 1'b1, 20);
		drive(1'b1, 1'b0, 20);
		drive(1'b0, 1'b0, 20);
		drive(1'b0, 1'b1, 20);
		drive(1'b1, 1'b1, 20);
	endtask
endmodule

//--- tb/rss_rtc_slave_tb.sv
// Self-checking bench for the serial slave and its test features.
// Assumes the master model drives the bus; the bench drives all else.
module rss_rtc_slave_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clock, rst_b, busClock, squareWaveSource, tick64In, oscStable, sqwDrv;
	logic        sdaOut, devSdaOe_b, sqwOut, sqwOe_b, regWrStrobe, secondTick, internalRst_b;
	logic        mSclOe_b, mSdaOe_b, sclWire, sdaWire, sqwWire;
	logic [7:0]  regRdAddr, regRdData, regWrAddr, regWrData;
	logic [15:0] wrQ[$];
	logic [15:0] rd;
	int          failures, n_checks, nTicks;

	assign sclWire = mSclOe_b;
	assign sdaWire = mSdaOe_b & (devSdaOe_b | sdaOut);
	assign sqwWire = sqwOe_b ? sqwDrv : sqwOut;
	assign regRdData = regRdAddr ^ 8'h5a;

	rss_rtc_slave rss_rtc_slave_i (.clock(clock), .rst_b(rst_b), .busClock(busClock),
		.sclIn(sclWire), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe_b(devSdaOe_b),
		.sqwIn(sqwWire), .sqwOut(sqwOut), .sqwOe_b(sqwOe_b),
		.squareWaveSource(squareWaveSource), .tick64In(tick64In), .oscStable(oscStable),
		.regRdAddr(regRdAddr), .regRdData(regRdData), .regWrAddr(regWrAddr),
		.regWrData(regWrData), .regWrStrobe(regWrStrobe), .secondTick(secondTick),
		.internalRst_b(internalRst_b));

	rss_bus_master rss_bus_master_i (.busClock(busClock), .sda(sdaWire),
		.sclOe_b(mSclOe_b), .sdaOe_b(mSdaOe_b));

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// Link clock offset so its edges never line up with the system clock
	initial begin
		busClock = 1'b0;
		#7;
		forever #16 busClock = ~busClock;
	end

	always @(posedge busClock) if (regWrStrobe === 1'b1) wrQ.push_back({regWrAddr, regWrData});
	always @(posedge clock) if (secondTick === 1'b1) nTicks++;

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d, failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic waitRst(input logic lvl);
		for (int i = 0; i < 200 && internalRst_b !== lvl; i++) @(negedge clock);
		check("internalRst_b", 16'(lvl), 16'(internalRst_b));
		if (internalRst_b !== lvl) wrap_up();
	endtask

	task automatic regWrite(input logic [7:0] b[$]);
		logic [7:0] rx;
		logic       ack;
		rss_bus_master_i.start();
		rss_bus_master_i.xfer(8'ha2, 1'b1, rx, ack);
		check("address ack", 16'h0, 16'(ack));
		foreach (b[i]) begin
			rss_bus_master_i.xfer(b[i], 1'b1, rx, ack);
			check("data ack", 16'h0, 16'(ack));
		end
		rss_bus_master_i.stop();
	endtask

	// Two bytes from a, last one left without acknowledge
	task automatic regRead(input logic [7:0] a, output logic [15:0] d);
		logic ack;
		rss_bus_master_i.start();
		rss_bus_master_i.xfer(8'ha2, 1'b1, d[7:0], ack);
		rss_bus_master_i.xfer(a, 1'b1, d[7:0], ack);
		rss_bus_master_i.start();
		rss_bus_master_i.xfer(8'ha3, 1'b1, d[7:0], ack);
		check("read address ack", 16'h0, 16'(ack));
		rss_bus_master_i.xfer(8'hff, 1'b0, d[15:8], ack);
		rss_bus_master_i.xfer(8'hff, 1'b1, d[7:0], ack);
		check("sda after nack", 16'h1, 16'(devSdaOe_b));
		rss_bus_master_i.stop();
	endtask

	task automatic pulses(input int n);
		repeat (n) begin
			@(negedge clock);
			sqwDrv = 1'b1;
			tick64In = 1'b1;
			repeat (130) @(negedge clock);
			sqwDrv = 1'b0;
			tick64In = 1'b0;
			repeat (130) @(negedge clock);
		end
	endtask

	task automatic t_reset();
		check("sqwOe_b", 16'h0, 16'(sqwOe_b));
		check("sqwOut", 16'h1, 16'(sqwOut));
		check("sdaOe_b idle", 16'h1, 16'(devSdaOe_b));
		check("sdaOut", 16'h0, 16'(sdaOut));
		check("internalRst_b", 16'h0, 16'(internalRst_b));
	endtask

	task automatic t_override();
		rss_bus_master_i.override();
		waitRst(1'b1);
		regRead(8'h00, rd);
		check("control reset", 16'h085b, rd);
	endtask

	task automatic t_transfers();
		logic [7:0] rx;
		logic       ack;
		regWrite('{8'h05, 8'h3c, 8'hc3});
		check("strobes", 16'h2, 16'(wrQ.size()));
		if (wrQ.size() == 2) begin
			check("first write", 16'h053c, wrQ[0]);
			check("second write", 16'h06c3, wrQ[1]);
		end
		rss_bus_master_i.start();
		rss_bus_master_i.xfer(8'ha4, 1'b1, rx, ack);
		check("foreign address ack", 16'h1, 16'(ack));
		rss_bus_master_i.stop();
		regRead(8'h10, rd);
		check("read bytes", 16'h4a4b, rd);
	endtask

	task automatic t_permit();
		regWrite('{8'h00, 8'h00});
		waitRst(1'b0);
		rss_bus_master_i.override();
		repeat (50) @(negedge clock);
		check("override blocked", 16'h0, 16'(internalRst_b));
		oscStable = 1'b1;
		waitRst(1'b1);
	endtask

	task automatic t_testMode();
		regWrite('{8'h00, 8'ha8});
		check("sqwOe_b test", 16'h1, 16'(sqwOe_b));
		nTicks = 0;
		pulses(40);
		check("ticks halted", 16'h0, 16'(nTicks));
		regWrite('{8'h00, 8'h88});
		pulses(31);
		check("ticks at 31", 16'h0, 16'(nTicks));
		pulses(1);
		check("ticks at 32", 16'h1, 16'(nTicks));
		pulses(63);
		check("ticks at 95", 16'h1, 16'(nTicks));
		pulses(1);
		check("ticks at 96", 16'h2, 16'(nTicks));
	endtask

	initial begin
		rst_b = 1'b0;
		squareWaveSource = 1'b1;
		tick64In = 1'b0;
		oscStable = 1'b0;
		sqwDrv = 1'b0;
		// Held for ten link clocks, since the slower domain must see it
		repeat (10) @(negedge busClock);
		rst_b = 1'b1;
		repeat (4) @(negedge busClock);
		t_reset();
		t_override();
		t_transfers();
		t_permit();
		t_testMode();
		wrap_up();
	end
endmodule
